// ### rtl/lab_ctrl_map.vh
/*
  Constants for the logic array block control generator: register byte
  offsets, control field layout, reset values and source codes.
  Assumes it is included by bare name from the design files.
*/
`ifndef LAB_CTRL_MAP_VH
`define LAB_CTRL_MAP_VH

// Register byte offsets on the Avalon-MM slave
`define OFS_SEL_LO      8'h00
`define OFS_SEL_HI      8'h04
`define OFS_MODE        8'h08
`define OFS_ROUTE       8'h0C
`define OFS_STATUS      8'h10

// Each control has a 4-bit source field: bits 2:0 source, bit 3 invert
`define SRC_W           4
`define SRC_LOCAL       3'h6
`define SRC_OFF         3'h7
`define ROW_LINES       6

// Control index inside the 40-bit selection vector
`define CTL_CLK1        0
`define CTL_CLK2        1
`define CTL_ENA1        2
`define CTL_ENA2        3
`define CTL_ACLR1       4
`define CTL_ACLR2       5
`define CTL_ALOAD       6
`define CTL_SCLR        7
`define CTL_SLOAD       8
`define CTL_ADDNSUB     9
`define CTL_COUNT       10

// Reset values: every control unused, both enables tied active
`define RST_SEL_LO      32'h7777FF77
`define RST_SEL_HI      8'h77
`define RST_MODE        30'h0000_0000
`define RST_ROUTE       20'h0_0000

// Field positions in the mode, route and status registers
`define MODE_ARITH_LSB  0
`define MODE_LUTCH_LSB  10
`define MODE_REGCH_LSB  20
`define ROUTE_CLK_LSB   0
`define ROUTE_ACLR_LSB  10
`define STAT_REG_LSB    0
`define STAT_LUT_LSB    10
`define STAT_CTL_LSB    20

`endif

// ### rtl/sync_two_flop.v
/*
  Two-flop synchroniser for a bus of independent level signals.
  Assumes each bit is a slow level from outside the mclk_in domain.
*/
`timescale 1ns/10ps

module sync_two_flop #(
  parameter WIDTH = 1
) (
  input  wire             mclk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  // First stage feeds only the second stage
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      meta_q   <= {WIDTH{1'b0}};
      stable_q <= {WIDTH{1'b0}};
    end else begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule // sync_two_flop

// ### rtl/logic_element_cell.v
/*
  One logic element: a small LUT function, carry logic and a register
  with clear, load and chain inputs.
  Assumes all inputs are on mclk_in and that the block clock arrives as
  a one-cycle tick enable from the control generator.
*/
`timescale 1ns/10ps

module logic_element_cell (
  input  wire mclk_in,
  input  wire rst_n_in,
  input  wire tick_in,
  input  wire aclr_in,
  input  wire aload_in,
  input  wire adata_in,
  input  wire sclr_in,
  input  wire sload_in,
  input  wire a_in,
  input  wire b_in,
  input  wire carry_in,
  input  wire arith_in,
  input  wire lut_chain_in,
  input  wire use_lut_chain_in,
  input  wire reg_chain_in,
  input  wire use_reg_chain_in,
  output wire lut_out,
  output wire carry_out,
  output wire q_out
);

  reg  q_q;
  wire chain_term;
  wire reg_d;

  // Arithmetic gives a sum bit; normal mode cascades a parity term
  assign chain_term = use_lut_chain_in & lut_chain_in;
  assign lut_out    = arith_in ? (a_in ^ b_in ^ carry_in)
                               : (a_in ^ b_in ^ chain_term);
  assign carry_out  = (a_in & b_in) | (carry_in & (a_in ^ b_in));

  // Register data comes from the LUT or from the neighbour register
  assign reg_d = use_reg_chain_in ? reg_chain_in : lut_out;

  // Clear and load act at once; clock-gated actions wait for the tick
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      q_q <= 1'b0;
    end else if (aclr_in) begin
      q_q <= 1'b0;
    end else if (aload_in) begin
      q_q <= adata_in;
    end else if (tick_in) begin
      if (sclr_in) begin
        q_q <= 1'b0;
      end else if (sload_in) begin
        q_q <= adata_in;
      end else begin
        q_q <= reg_d;
      end
    end
  end

  assign q_out = q_q;

endmodule // logic_element_cell

// ### rtl/lab_control_signal_gen.v
/*
  Control signal generator for one logic_array_block of ten
  logic_element cells, with an Avalon-MM register slave that selects
  each block-wide control from the row clock lines or local lines.
  Assumes one clock mclk_in, a synchronous active-low reset, and that
  row, local and data inputs come from outside this clock domain.
*/
// Implementation choices: the placing of the registers and register access over Avalon-MM.
// Summary of operation
// - Ten logic elements share one control set
// - Ten controls: clocks, enables, clears, loads, addnsub
// - Each block clock paired with its own enable
// - Both clock lines supply rising and falling edges
// - Deasserted enable suppresses its block clock
// - Async load takes data input; high gives preset
// - Controls chosen from row clocks five..zero, local
// - Addnsub makes each element add or subtract
// - LUT chain passes LUT output to neighbour
// - Register chain shifts register into neighbour
// - Subtract inverts B and forces first carry
// - Sync clear and load act block-wide on edge
`timescale 1ns/10ps
`include "lab_ctrl_map.vh"

module lab_control_signal_gen #(
  parameter ELEMENTS = 10
) (
  input  wire                 mclk_in,
  input  wire                 rst_n_in,
  input  wire [7:0]           avs_address_in,
  input  wire                 avs_read_in,
  input  wire                 avs_write_in,
  input  wire [31:0]          avs_writedata_in,
  output wire [31:0]          avs_readdata_out,
  output wire                 avs_waitrequest_out,
  input  wire [5:0]           row_clock_in,
  input  wire [9:0]           local_ctrl_in,
  input  wire [ELEMENTS-1:0]  data_a_in,
  input  wire [ELEMENTS-1:0]  data_b_in,
  input  wire [ELEMENTS-1:0]  async_data_in,
  output wire [ELEMENTS-1:0]  lut_out,
  output wire [ELEMENTS-1:0]  reg_out,
  output wire                 carry_out
);

  // Picks one control level from its source field
  // Codes 0 to 5 name a row line, 6 the control's own local line and
  // 7 a constant low; the invert bit then turns any of these around,
  // so a constant high comes from code 7 with the invert bit set
  function pick_source;
    input [`SRC_W-1:0]     sel;
    input [`ROW_LINES-1:0] row;
    input                  loc;
    reg                    lvl;
    begin
      lvl = 1'b0;
      if (sel[2:0] < `SRC_LOCAL) begin
        lvl = row[sel[2:0]];
      end else if (sel[2:0] == `SRC_LOCAL) begin
        lvl = loc;
      end
      pick_source = lvl ^ sel[3];
    end
  endfunction

  // Registers written by software
  reg  [39:0]          sel_q;
  reg  [29:0]          mode_q;
  reg  [19:0]          route_q;

  // Bus slave state
  reg                  wait_q;
  reg  [31:0]          rdata_q;
  reg  [31:0]          rdata_d;

  // Clock edge detection state
  reg  [1:0]           clk_prev_q;

  // Registered copies of element outputs
  reg  [ELEMENTS-1:0]  lut_q;
  reg                  carry_q;

  // Synchronised outside inputs
  wire [5:0]           row_s;
  wire [9:0]           local_s;
  wire [ELEMENTS-1:0]  a_s;
  wire [ELEMENTS-1:0]  b_s;
  wire [ELEMENTS-1:0]  adata_s;

  // Control levels and derived enables
  wire [`CTL_COUNT-1:0] ctl_lvl;
  wire [1:0]           clk_edge;
  wire [1:0]           tick;
  wire                 addnsub;
  wire [ELEMENTS-1:0]  b_eff;

  // Element wiring
  wire [ELEMENTS-1:0]  lut_w;
  wire [ELEMENTS-1:0]  q_w;
  wire [ELEMENTS:0]    carry_w;
  wire [ELEMENTS-1:0]  arith;
  wire [ELEMENTS-1:0]  use_lut_chain;
  wire [ELEMENTS-1:0]  use_reg_chain;
  wire [ELEMENTS-1:0]  clk_route;
  wire [ELEMENTS-1:0]  aclr_route;

  // Bus request decode
  wire                 req;
  wire                 do_write;

  // Row clock and local lines cross into mclk_in
  // Each bit is synchronised on its own; a row line that changes while
  // another source is selected costs nothing, and a selected line is
  // seen two cycles after its pin moves
  sync_two_flop #(
    .WIDTH (16)
  ) u_sync_ctrl (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .async_in ({local_ctrl_in, row_clock_in}),
    .sync_out ({local_s, row_s})
  );

  // Element data inputs cross into mclk_in
  // Data and block clock share the same two-cycle delay, so a data
  // change made with a row line edge still meets that edge
  sync_two_flop #(
    .WIDTH (3 * ELEMENTS)
  ) u_sync_data (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .async_in ({async_data_in, data_b_in, data_a_in}),
    .sync_out ({adata_s, b_s, a_s})
  );

  // Avalon-MM slave: answer one cycle after the request is seen
  // Waitrequest idles high and drops for exactly one cycle per access,
  // so every read or write takes two cycles and back-to-back requests
  // never overlap; a master that holds its request past the answer
  // simply starts a second access
  assign req      = avs_read_in | avs_write_in;
  assign do_write = avs_write_in & ~wait_q;

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Read data selection; unmapped offsets read as zero
  // The status word shows live control levels, the registered LUT
  // results and the element registers side by side
  always @* begin
    rdata_d = 32'h0000_0000;
    case (avs_address_in)
      `OFS_SEL_LO: begin
        rdata_d = sel_q[31:0];
      end
      `OFS_SEL_HI: begin
        rdata_d = {24'h00_0000, sel_q[39:32]};
      end
      `OFS_MODE: begin
        rdata_d = {2'h0, mode_q};
      end
      `OFS_ROUTE: begin
        rdata_d = {12'h000, route_q};
      end
      `OFS_STATUS: begin
        rdata_d = {2'h0, ctl_lvl, lut_q, q_w};
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data is captured while waitrequest is still high
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_in && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  // Writes land on the edge where waitrequest is low
  // The two selection halves are written independently; software that
  // moves a control between halves should expect at least two mixed cycles
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sel_q   <= {`RST_SEL_HI, `RST_SEL_LO};
      mode_q  <= `RST_MODE;
      route_q <= `RST_ROUTE;
    end else if (do_write) begin
      case (avs_address_in)
        `OFS_SEL_LO: begin
          sel_q[31:0] <= avs_writedata_in;
        end
        `OFS_SEL_HI: begin
          sel_q[39:32] <= avs_writedata_in[7:0];
        end
        `OFS_MODE: begin
          mode_q <= avs_writedata_in[29:0];
        end
        `OFS_ROUTE: begin
          route_q <= avs_writedata_in[19:0];
        end
        default: begin
          mode_q <= mode_q;
        end
      endcase
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out    = rdata_q;

  // Ten control levels, one per source field, all block-wide
  // Every control is resolved once here and fanned out to all elements,
  // so no element can see a different version of a shared control
  genvar c;
  generate
    for (c = 0; c < `CTL_COUNT; c = c + 1) begin : g_ctl
      assign ctl_lvl[c] = pick_source(sel_q[c*`SRC_W +: `SRC_W],
                                      row_s, local_s[c]);
    end
  endgenerate

  // Previous block clock levels for edge detection
  // Starting from low means a clock source already high at release
  // gives one tick; software selects clock sources after reset anyway
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      clk_prev_q <= 2'h0;
    end else begin
      clk_prev_q <= {ctl_lvl[`CTL_CLK2], ctl_lvl[`CTL_CLK1]};
    end
  end

  // Invert bit turns a rising detector into a falling one, so one row
  // line driven on both block clocks serves both edges
  assign clk_edge = {ctl_lvl[`CTL_CLK2], ctl_lvl[`CTL_CLK1]}
                    & ~clk_prev_q;

  // Each block clock is gated only by its own enable, as a tick
  // No clock is ever gated: the enable only masks the one-cycle tick,
  // so a dropped enable simply loses the edges that fall while low
  assign tick[0] = clk_edge[0] & ctl_lvl[`CTL_ENA1];
  assign tick[1] = clk_edge[1] & ctl_lvl[`CTL_ENA2];

  // Subtraction inverts B and sets the first carry in
  // Element 0 holds the least significant bit; the same control both
  // inverts B and supplies the extra one of the two's complement
  assign addnsub    = ctl_lvl[`CTL_ADDNSUB];
  assign b_eff      = b_s ^ {ELEMENTS{addnsub}};
  assign carry_w[0] = addnsub;

  // Per-element mode and routing fields
  assign arith         = mode_q[`MODE_ARITH_LSB +: ELEMENTS];
  assign use_lut_chain = mode_q[`MODE_LUTCH_LSB +: ELEMENTS];
  assign use_reg_chain = mode_q[`MODE_REGCH_LSB +: ELEMENTS];
  assign clk_route     = route_q[`ROUTE_CLK_LSB +: ELEMENTS];
  assign aclr_route    = route_q[`ROUTE_ACLR_LSB +: ELEMENTS];

  // The ten elements share the same control set
  // Element 0 has no neighbour below it, so both of its chain inputs
  // are tied low; a register shift therefore fills with zeros
  genvar e;
  generate
    for (e = 0; e < ELEMENTS; e = e + 1) begin : g_le
      wire lut_prev;
      wire q_prev;
      if (e == 0) begin : g_first
        assign lut_prev = 1'b0;
        assign q_prev   = 1'b0;
      end else begin : g_next
        assign lut_prev = lut_w[e-1];
        assign q_prev   = q_w[e-1];
      end
      logic_element_cell u_cell (
        .mclk_in          (mclk_in),
        .rst_n_in         (rst_n_in),
        .tick_in          (clk_route[e] ? tick[1] : tick[0]),
        .aclr_in          (aclr_route[e] ? ctl_lvl[`CTL_ACLR2]
                                         : ctl_lvl[`CTL_ACLR1]),
        .aload_in         (ctl_lvl[`CTL_ALOAD]),
        .adata_in         (adata_s[e]),
        .sclr_in          (ctl_lvl[`CTL_SCLR]),
        .sload_in         (ctl_lvl[`CTL_SLOAD]),
        .a_in             (a_s[e]),
        .b_in             (b_eff[e]),
        .carry_in         (carry_w[e]),
        .arith_in         (arith[e]),
        .lut_chain_in     (lut_prev),
        .use_lut_chain_in (use_lut_chain[e]),
        .reg_chain_in     (q_prev),
        .use_reg_chain_in (use_reg_chain[e]),
        .lut_out          (lut_w[e]),
        .carry_out        (carry_w[e+1]),
        .q_out            (q_w[e])
      );
    end
  endgenerate

  // LUT results and final carry are registered before leaving
  // This adds one cycle to the combinational results but keeps every
  // output of the block on a flip-flop
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      lut_q   <= {ELEMENTS{1'b0}};
      carry_q <= 1'b0;
    end else begin
      lut_q   <= lut_w;
      carry_q <= carry_w[ELEMENTS];
    end
  end

  assign lut_out   = lut_q;
  assign reg_out   = q_w;
  assign carry_out = carry_q;

endmodule // lab_control_signal_gen

// ### bench/row_line_source.sv
/* Partner: drives row line 0 high for a few cycles per request.
   Assumes the bench raises fire_in for one cycle. */
`timescale 1ns/10ps
module row_line_source (
  input  wire       mclk_in,
  input  wire       fire_in,
  output reg  [5:0] row_clock_out
);
  reg [2:0] hold_q;
  initial begin
    row_clock_out = 6'h00;
    hold_q = 3'h0;
  end
  // Line 0 pulses, all lines stand low between pulses
  always @(posedge mclk_in) begin
    if (fire_in) hold_q <= 3'h6;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    row_clock_out <= {5'h00, fire_in || hold_q > 3'h1};
  end
endmodule // row_line_source

// ### bench/lab_ctrl_props.sv
/* Checker for the bus handshake and output stability.
   Assumes it is bound to lab_control_signal_gen. */
`timescale 1ns/10ps
module lab_ctrl_props #(parameter ELEMENTS = 10) (
  input wire                mclk_in,
  input wire                rst_n_in,
  input wire [7:0]          avs_address_in,
  input wire                avs_read_in,
  input wire                avs_write_in,
  input wire [31:0]         avs_readdata_out,
  input wire                avs_waitrequest_out,
  input wire [5:0]          row_clock_in,
  input wire [9:0]          local_ctrl_in,
  input wire [ELEMENTS-1:0] data_a_in,
  input wire [ELEMENTS-1:0] data_b_in,
  input wire [ELEMENTS-1:0] async_data_in,
  input wire [ELEMENTS-1:0] lut_out,
  input wire [ELEMENTS-1:0] reg_out,
  input wire                carry_out
);
  localparam IW = 16 + 3 * ELEMENTS;
  wire [IW-1:0] now_w = {row_clock_in, local_ctrl_in, data_a_in,
                         data_b_in, async_data_in};
  reg  [IW-1:0] seen_q;
  reg  [7:0]    quiet_q;
  // Counts cycles with no input change and no register write
  always @(posedge mclk_in) begin
    seen_q <= now_w;
    if (!rst_n_in || now_w != seen_q || avs_write_in) quiet_q <= 8'h00;
    else if (quiet_q != 8'hFF) quiet_q <= quiet_q + 8'h01;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_wait_one;
    $fell(avs_waitrequest_out) |=> avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low longer than one cycle");
  property p_wait_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("no answer one cycle after request");
  property p_wait_cause;
    !avs_waitrequest_out |-> $past(avs_read_in) || $past(avs_write_in);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("answer without request");
  property p_unmapped;
    avs_read_in && avs_waitrequest_out && avs_address_in == 8'h14
      |=> avs_readdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_status;
    avs_read_in && avs_waitrequest_out && avs_address_in == 8'h10
      |=> avs_readdata_out[ELEMENTS-1:0] == $past(reg_out);
  endproperty
  a_status: assert property (p_status)
    else $error("status does not show registers");
  property p_rdata_hold;
    !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");
  property p_reg_quiet;
    quiet_q >= 8'h08 |-> $stable(reg_out);
  endproperty
  a_reg_quiet: assert property (p_reg_quiet)
    else $error("register moved without cause");
  property p_lut_quiet;
    quiet_q >= 8'h08 |-> $stable(lut_out) && $stable(carry_out);
  endproperty
  a_lut_quiet: assert property (p_lut_quiet)
    else $error("lut or carry moved without cause");
endmodule // lab_ctrl_props
bind lab_control_signal_gen lab_ctrl_props #(.ELEMENTS(ELEMENTS)) props_u (
  .mclk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .row_clock_in, .local_ctrl_in,
  .data_a_in, .data_b_in, .async_data_in, .lut_out, .reg_out, .carry_out);

// ### bench/lab_control_signal_gen_tb.sv
/* Self-checking bench: register bus, arithmetic, enables, register chain, loads.
   Assumes the partner drives row line 0 on request. */
`timescale 1ns/10ps
module lab_control_signal_gen_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wd = 32'h0;
  reg  [9:0]  loc = 10'h0;
  reg  [9:0]  a = 10'h0;
  reg  [9:0]  b = 10'h0;
  reg  [9:0]  ad = 10'h0;
  reg         fire = 1'b0;
  wire [31:0] rdata;
  wire        wait_w;
  wire [5:0]  row;
  wire [9:0]  lut;
  wire [9:0]  regq;
  wire        cout;
  integer     mismatches = 0;
  integer     samples_checked = 0;
  integer     cycles = 0;
  integer     seed = 23547;
  integer     i;
  reg  [31:0] exp_q [$];
  reg  [10:0] sum;
  always #5 clk = ~clk;
  lab_control_signal_gen dut_u (.mclk_in(clk), .rst_n_in(rst_n),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_w), .row_clock_in(row),
    .local_ctrl_in(loc), .data_a_in(a), .data_b_in(b),
    .async_data_in(ad), .lut_out(lut), .reg_out(regq), .carry_out(cout));
  row_line_source src_u (.mclk_in(clk), .fire_in(fire),
    .row_clock_out(row));
  task complete_run;
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input string n, input [31:0] e, input [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(input w, input [7:0] ad_i, input [31:0] d);
    @(posedge clk);
    adr <= ad_i; wd <= d; wr <= w; rd <= !w;
    do @(posedge clk); while (wait_w !== 1'b0);
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task rdc(input [7:0] ad_i, input [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, ad_i, 32'h0);
  endtask
  task pulse;
    @(posedge clk) fire <= 1'b1;
    @(posedge clk) fire <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
  // Compares each read answer with the oldest noted value
  always @(posedge clk)
    if (rd === 1'b1 && wait_w === 1'b0) check("rdata", exp_q.pop_front(), rdata);
  // Cuts a hang short
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    loc <= $random(seed);
    rdc(8'h00, 32'h7777FF77); rdc(8'h04, 32'h77); rdc(8'h08, 32'h0);
    rdc(8'h0C, 32'h0); rdc(8'h14, 32'h0);
    rdc(8'h10, 32'h00C0_0000);
    bus(1'b1, 8'h00, 32'h7777FF70);
    bus(1'b1, 8'h08, 32'h3FF); rdc(8'h08, 32'h3FF);
    for (i = 0; i < 3; i = i + 1) begin
      bus(1'b1, 8'h04, i ? 32'hF7 : 32'h77);
      if (i == 2) bus(1'b1, 8'h00, 32'h77777F70);
      a <= $random(seed); b <= $random(seed); pulse;
      sum = i ? {1'b0, a} + {1'b0, ~b} + 11'h1 : {1'b0, a} + {1'b0, b};
      check("reg", sum[9:0], regq);
      check("lut", sum[9:0], lut);
      check("carry", sum[10], cout);
    end
    bus(1'b1, 8'h00, 32'h7777F770); a <= ~a; pulse;
    check("hold", sum[9:0], regq);
    ad <= $random(seed); bus(1'b1, 8'h00, 32'h7F77FF87);
    repeat (8) @(posedge clk);
    check("aload", ad, regq);
    ad <= 10'h3FF; repeat (8) @(posedge clk);
    check("preset", 10'h3FF, regq);
    bus(1'b1, 8'h00, 32'h7777FF87); bus(1'b1, 8'h0C, 32'h3FF);
    bus(1'b1, 8'h08, 32'h3FF00000);
    pulse; check("shift1", 10'h3FE, regq);
    pulse; check("shift2", 10'h3FC, regq);
    bus(1'b1, 8'h04, 32'h7F); bus(1'b1, 8'h00, 32'hF777FF87);
    pulse; check("sclr", 10'h0, regq);
    repeat (4) @(posedge clk);
    complete_run;
  end
endmodule // lab_control_signal_gen_tb
